// file: hw/iosc_cfg.svh
/*
  constants for the internal oscillator and system clock control:
  register addresses, field positions, reset values, timing counts.
  assumes inclusion by bare name from the design and bench files.
*/
`ifndef IOSC_CFG_SVH
`define IOSC_CFG_SVH

// special function register addresses
`define IOSC_CTRL_ADDR 8'hB2
`define IOSC_TRIM_ADDR 8'hB3

// control register fields and reset value
`define IOSC_CTRL_RESET 8'h80
`define IOSC_EN_BIT 7
`define IOSC_RDY_BIT 6
`define IOSC_SUSP_BIT 5
`define IOSC_DIV_MSB 1
`define IOSC_DIV_LSB 0
`define IOSC_DIV_RESET 2'h0
`define IOSC_ZERO_FIELD 3'h0

// trim register field
`define IOSC_TRIM_MSB 4
`define IOSC_TRIM_PAD 3'h0

// period change per trim step, parts per million of the base period
`define IOSC_TRIM_STEP_PPM 2500

// timing: clock period and oscillator settle time
`define IOSC_CLK_PERIOD_NS 10
`define IOSC_SETTLE_NS 1000
`define IOSC_SETTLE_CYC \
  ((`IOSC_SETTLE_NS + `IOSC_CLK_PERIOD_NS - 1) / `IOSC_CLK_PERIOD_NS)

`endif

// file: hw/iosc_pkg.sv
/*
  types for the internal oscillator and system clock control.
  assumes iosc_cfg.svh for all numeric constants.
*/
package iosc_pkg;

  // register port request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic [7:0] wrData;
  } iosc_sfr_req_s;

  // software-visible control fields
  typedef struct packed {
    logic enable;
    logic [1:0] divSel;
  } iosc_ctrl_s;

  // system clock sources
  typedef enum logic [1:0] {
    SYS_SRC_INT,
    SYS_SRC_EXT,
    SYS_SRC_MULT_HALF
  } iosc_sys_src_e;

  // usb clock sources
  typedef enum logic [1:0] {
    USB_SRC_INT,
    USB_SRC_EXT,
    USB_SRC_MULT
  } iosc_usb_src_e;

  // oscillator state
  typedef enum logic [1:0] {
    OSC_STOPPED,
    OSC_SETTLING,
    OSC_READY,
    OSC_SUSPENDED
  } iosc_state_e;

endpackage : iosc_pkg

// file: hw/iosc_trim_store.sv
/*
  holds the five-bit oscillator trim value.
  assumes factoryValue is stable while reset is held; the stored
  value is presented straight from its register.
*/
`timescale 1ns/100ps
`include "iosc_cfg.svh"

module iosc_trim_store
  import iosc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [`IOSC_TRIM_MSB:0] factoryValue,
  input wire logic wrEn,
  input wire logic [`IOSC_TRIM_MSB:0] wrData,
  output logic [`IOSC_TRIM_MSB:0] trimValue
);

  logic [`IOSC_TRIM_MSB:0] trim_reg;
  logic [`IOSC_TRIM_MSB:0] trim_next;

  // reload factory value on every reset, software writes otherwise
  always_comb begin
    if (!reset_n) begin
      trim_next = factoryValue; // see (RULE_12)
    end else if (wrEn) begin
      trim_next = wrData; // see (RULE_15)
    end else begin
      trim_next = trim_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    trim_reg <= trim_next;
  end

  assign trimValue = trim_reg;

endmodule : iosc_trim_store

// file: hw/iosc_system_clock_control.sv
/*
  internal oscillator control: registers, enable, ready, suspend,
  resume event, system clock divider and clock source selection.
  assumes a byte-wide register port on sys_clk, async pins, static trim.
  // Operation
  // (RULE_01) reset selects internal oscillator for system clock
  // (RULE_02) system clock: internal, external, multiplier halved
  // (RULE_03) usb clock: internal, external or multiplier
  // (RULE_04) bits 1:0 divide by 8, 4, 2, 1
  // (RULE_05) divider defaults to divide by eight
  // (RULE_06) bit 7 runs or stops oscillator, resets 1
  // (RULE_07) writing 1 to bit 5 suspends oscillator
  // (RULE_08) suspend ends on usb activity or supply match
  // (RULE_09) usb activity in suspend raises resume event
  // (RULE_10) software re-enables transceiver after resume event
  // (RULE_11) one trim step shifts period about 0.0025
  // (RULE_12) every reset reloads factory trim value
  // (RULE_13) software keeps adjusted trim within 0 to 31
  // (RULE_14) modified trim forbids internal usb clock
  // (RULE_15) trim register bits 4:0 hold trim value
  // (RULE_16) trim contents undefined during clock recovery
  // (RULE_17) bit 6 reads 1 when oscillator stable
  // (RULE_18) bits 4:2 read zero, writes ignored
*/
`timescale 1ns/100ps
`include "iosc_cfg.svh"

module iosc_system_clock_control
  import iosc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire iosc_sfr_req_s sfrReq,
  input wire logic usbNonIdleAsync,
  input wire logic vbusLevelAsync,
  input wire logic vbusPolaritySelect,
  input wire logic clockRecoveryEn,
  input wire logic [`IOSC_TRIM_MSB:0] factoryTrim,
  input wire logic [1:0] sysclkSourceReq,
  input wire logic [1:0] usbClockReq,
  output logic [7:0] sfrRdData,
  output logic intOscRun,
  output logic intOscFreqReady,
  output logic sysclkTick,
  output iosc_sys_src_e sysclkSource,
  output iosc_usb_src_e usbClockSource,
  output logic [`IOSC_TRIM_MSB:0] trimValue,
  output logic signed [5:0] trimDelta,
  output logic trimModified,
  output logic resumeIrq
);

  localparam int SettleCycles = `IOSC_SETTLE_CYC;
  localparam logic [7:0] SettleLast = 8'(SettleCycles - 1);

  // pin synchronisers: first stage feeds only the second
  logic usbSync1_reg, usbSync2_reg, usbSync3_reg;
  logic vbusSync1_reg, vbusSync2_reg;
  logic [`IOSC_TRIM_MSB:0] factSync1_reg, factSync2_reg;

  // factory value is not reset so it is valid while reset is held
  always_ff @(posedge sys_clk) begin
    factSync1_reg <= factoryTrim;
    factSync2_reg <= factSync1_reg;
    if (!reset_n) begin
      usbSync1_reg <= 1'b0;
      usbSync2_reg <= 1'b0;
      usbSync3_reg <= 1'b0;
      vbusSync1_reg <= 1'b0;
      vbusSync2_reg <= 1'b0;
    end else begin
      usbSync1_reg <= usbNonIdleAsync;
      usbSync2_reg <= usbSync1_reg;
      usbSync3_reg <= usbSync2_reg;
      vbusSync1_reg <= vbusLevelAsync;
      vbusSync2_reg <= vbusSync1_reg;
    end
  end

  logic nonIdleRise, vbusMatch, wake;
  logic wrCtrl, wrTrim;

  // transceiver activity is watched in every state, suspend included
  assign nonIdleRise = usbSync2_reg & ~usbSync3_reg; // see (RULE_09)
  assign vbusMatch = (vbusSync2_reg == vbusPolaritySelect);
  assign wake = nonIdleRise | vbusMatch; // see (RULE_08)
  assign wrCtrl = sfrReq.wrEn && (sfrReq.addr == `IOSC_CTRL_ADDR);
  // trim is owned by clock recovery while it runs
  assign wrTrim = sfrReq.wrEn && (sfrReq.addr == `IOSC_TRIM_ADDR)
                  && !clockRecoveryEn; // see (RULE_16)

  // control register and suspend flag
  iosc_ctrl_s ctrl_reg, ctrl_next;
  logic suspend_reg, suspend_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrCtrl) begin
      ctrl_next.enable = sfrReq.wrData[`IOSC_EN_BIT]; // see (RULE_06)
      ctrl_next.divSel =
        sfrReq.wrData[`IOSC_DIV_MSB:`IOSC_DIV_LSB]; // see (RULE_04)
    end
    // a suspend write in the wake cycle still takes effect
    suspend_next = (suspend_reg & ~wake)
                 | (wrCtrl & sfrReq.wrData[`IOSC_SUSP_BIT]); // see (RULE_07)
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_reg.enable <= 1'(`IOSC_CTRL_RESET >> `IOSC_EN_BIT); // see (RULE_06)
      ctrl_reg.divSel <= `IOSC_DIV_RESET; // see (RULE_05)
      suspend_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      suspend_reg <= suspend_next;
    end
  end

  // oscillator state machine with settle counter
  iosc_state_e state_reg, state_next;
  logic [7:0] settle_reg, settle_next;
  logic run_next;
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      OSC_STOPPED: begin
        settle_next = 8'h00;
        if (suspend_reg) begin
          state_next = OSC_SUSPENDED;
        end else if (ctrl_reg.enable) begin
          state_next = OSC_SETTLING;
        end
      end
      OSC_SETTLING: begin
        settle_next = settle_reg + 8'h01;
        if (!ctrl_reg.enable) begin
          state_next = OSC_STOPPED; // see (RULE_06)
        end else if (suspend_reg) begin
          state_next = OSC_SUSPENDED; // see (RULE_07)
        end else if (settle_reg == SettleLast) begin
          state_next = OSC_READY; // see (RULE_17)
        end
      end
      OSC_READY: begin
        if (!ctrl_reg.enable) begin
          state_next = OSC_STOPPED;
        end else if (suspend_reg) begin
          state_next = OSC_SUSPENDED;
        end
      end
      OSC_SUSPENDED: begin
        settle_next = 8'h00;
        // stays stopped until activity or a matching supply level
        if (!suspend_reg) begin
          state_next = ctrl_reg.enable ? OSC_SETTLING
                                       : OSC_STOPPED; // see (RULE_08)
        end
      end
      default: begin
        state_next = OSC_STOPPED;
        settle_next = 8'h00;
      end
    endcase
    run_next = (state_next == OSC_SETTLING) || (state_next == OSC_READY);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= OSC_STOPPED;
      settle_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      settle_reg <= settle_next;
    end
  end

  // divider: limit is ratio minus one, 7, 3, 1 or 0
  logic [2:0] div_reg, div_next, divLimit;
  logic tick_next;
  always_comb begin
    divLimit = 3'h7 >> ctrl_reg.divSel; // see (RULE_04)
    tick_next = 1'b0;
    div_next = 3'h0;
    if (intOscRun) begin
      if (div_reg >= divLimit) begin
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 3'h1;
      end
    end
  end

  // clock source selection; unknown request codes are ignored
  iosc_sys_src_e sysSrc_next;
  iosc_usb_src_e usbSrc_next;
  always_comb begin
    case (sysclkSourceReq)
      2'h0: sysSrc_next = SYS_SRC_INT; // see (RULE_02)
      2'h1: sysSrc_next = SYS_SRC_EXT;
      2'h2: sysSrc_next = SYS_SRC_MULT_HALF;
      default: sysSrc_next = sysclkSource;
    endcase
    case (usbClockReq)
      2'h0: usbSrc_next = USB_SRC_INT; // see (RULE_03)
      2'h1: usbSrc_next = USB_SRC_EXT;
      2'h2: usbSrc_next = USB_SRC_MULT;
      default: usbSrc_next = usbClockSource;
    endcase
  end

  // trim store and the factory reference kept for the delta
  logic [`IOSC_TRIM_MSB:0] factRef_reg, factRef_next;
  iosc_trim_store trimStore (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .factoryValue(factSync2_reg),
    .wrEn(wrTrim),
    .wrData(sfrReq.wrData[`IOSC_TRIM_MSB:0]),
    .trimValue(trimValue)
  );
  assign factRef_next = reset_n ? factRef_reg : factSync2_reg;

  // read data and status outputs
  logic [7:0] rd_next;
  logic signed [5:0] delta_next;
  logic modified_next;
  always_comb begin
    rd_next = sfrRdData;
    if (sfrReq.rdEn) begin
      case (sfrReq.addr)
        `IOSC_CTRL_ADDR: rd_next = {ctrl_reg.enable, intOscFreqReady,
                                    suspend_reg, `IOSC_ZERO_FIELD,
                                    ctrl_reg.divSel}; // see (RULE_18)
        `IOSC_TRIM_ADDR: rd_next = clockRecoveryEn ? 8'h00
                         : {`IOSC_TRIM_PAD, trimValue}; // see (RULE_16)
        default: rd_next = 8'h00;
      endcase
    end
    // period change is this delta times the per-step fraction
    delta_next = $signed({1'b0, trimValue})
               - $signed({1'b0, factRef_reg}); // see (RULE_11)
    // flags that the oscillator is no longer a valid usb clock
    modified_next = trimModified | wrTrim; // see (RULE_14)
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_reg <= 3'h0;
      sysclkTick <= 1'b0;
      intOscRun <= 1'b0;
      intOscFreqReady <= 1'b0;
      sysclkSource <= SYS_SRC_INT; // see (RULE_01)
      usbClockSource <= USB_SRC_INT;
      sfrRdData <= 8'h00;
      trimDelta <= 6'sh00;
      trimModified <= 1'b0;
      resumeIrq <= 1'b0;
      factRef_reg <= factRef_next;
    end else begin
      div_reg <= div_next;
      sysclkTick <= tick_next;
      intOscRun <= run_next;
      intOscFreqReady <= (state_next == OSC_READY); // see (RULE_17)
      sysclkSource <= sysSrc_next;
      usbClockSource <= usbSrc_next;
      sfrRdData <= rd_next;
      trimDelta <= delta_next;
      trimModified <= modified_next;
      resumeIrq <= nonIdleRise & suspend_reg; // see (RULE_09)
      factRef_reg <= factRef_next;
    end
  end

  // helper: consecutive cycles the oscillator has been running
  logic [7:0] runCount_reg;
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !intOscRun) begin
      runCount_reg <= 8'h00;
    end else if (runCount_reg != 8'hFF) begin
      runCount_reg <= runCount_reg + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_suspend_write;
    wrCtrl && sfrReq.wrData[`IOSC_SUSP_BIT];
  endsequence
  sequence s_osc_halted;
    suspend_reg ##1 !intOscRun;
  endsequence
  a_reset_src_int: assert property ( // see (RULE_01)
    $rose(reset_n) |-> sysclkSource == SYS_SRC_INT)
    else $error("system clock source not internal after reset");
  a_sys_src_ext: assert property ( // see (RULE_02)
    sysclkSourceReq == 2'h1 |=> sysclkSource == SYS_SRC_EXT)
    else $error("external system clock request not applied");
  a_usb_src_mult: assert property ( // see (RULE_03)
    usbClockReq == 2'h2 |=> usbClockSource == USB_SRC_MULT)
    else $error("multiplier usb clock request not applied");
  a_div_one_tick: assert property ( // see (RULE_04)
    (ctrl_reg.divSel == 2'h3 && state_reg == OSC_READY && !wrCtrl)[*2]
    |-> sysclkTick)
    else $error("divide by one missed a tick");
  a_reset_div8: assert property ( // see (RULE_05)
    $rose(reset_n) |-> ctrl_reg.divSel == 2'h0 && ctrl_reg.enable)
    else $error("control register not at reset value");
  a_enable_stops: assert property ( // see (RULE_06)
    !ctrl_reg.enable |=> !intOscRun)
    else $error("oscillator runs while disabled");
  a_suspend_stops: assert property ( // see (RULE_07)
    s_suspend_write |=> s_osc_halted)
    else $error("suspend write did not stop oscillator");
  // suspend flag already cleared by a wake means restart is legal
  a_stay_suspended: assert property ( // see (RULE_08)
    state_reg == OSC_SUSPENDED && suspend_reg && !wake |=> !intOscRun)
    else $error("oscillator left suspend without wake");
  a_resume_event: assert property ( // see (RULE_09)
    nonIdleRise && suspend_reg |=> resumeIrq)
    else $error("resume event missing");
  a_trim_reload: assert property ( // see (RULE_12)
    $rose(reset_n) |-> trimValue == $past(factSync2_reg))
    else $error("trim not reloaded by reset");
  a_trim_write: assert property ( // see (RULE_15)
    wrTrim |=> trimValue == $past(sfrReq.wrData[`IOSC_TRIM_MSB:0]))
    else $error("trim write not stored");
  a_trim_recovery: assert property ( // see (RULE_16)
    sfrReq.rdEn && sfrReq.addr == `IOSC_TRIM_ADDR && clockRecoveryEn
    |=> sfrRdData == 8'h00)
    else $error("trim readable during clock recovery");
  a_ready_settle: assert property ( // see (RULE_17)
    $rose(intOscFreqReady) |-> runCount_reg == 8'(SettleCycles))
    else $error("ready flag not at settle time");
  a_unused_zero: assert property ( // see (RULE_18)
    sfrReq.rdEn && sfrReq.addr == `IOSC_CTRL_ADDR
    |=> sfrRdData[4:2] == 3'h0)
    else $error("unused control bits read nonzero");

endmodule : iosc_system_clock_control

// file: verif/iosc_system_clock_control_tb_top.sv
/*
  self-checking bench for the internal oscillator control block.
  assumes hw/ on the include path and the design compiled first.
*/
`timescale 1ns/100ps
`include "iosc_cfg.svh"

module iosc_system_clock_control_tb_top
  import iosc_pkg::*;
;
  logic sys_clk;
  logic reset_n;
  iosc_sfr_req_s sfrReq;
  logic usbNonIdleAsync;
  logic vbusLevelAsync;
  logic vbusPolaritySelect;
  logic clockRecoveryEn;
  logic [4:0] factoryTrim;
  logic [1:0] sysclkSourceReq;
  logic [1:0] usbClockReq;
  logic [7:0] sfrRdData;
  logic intOscRun;
  logic intOscFreqReady;
  logic sysclkTick;
  iosc_sys_src_e sysclkSource;
  iosc_usb_src_e usbClockSource;
  logic [4:0] trimValue;
  logic signed [5:0] trimDelta;
  logic trimModified;
  logic resumeIrq;
  logic [7:0] rd;
  int failCount;
  int checkCount;
  int n;

  iosc_system_clock_control DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .sfrReq(sfrReq),
    .usbNonIdleAsync(usbNonIdleAsync), .vbusLevelAsync(vbusLevelAsync),
    .vbusPolaritySelect(vbusPolaritySelect),
    .clockRecoveryEn(clockRecoveryEn), .factoryTrim(factoryTrim),
    .sysclkSourceReq(sysclkSourceReq), .usbClockReq(usbClockReq),
    .sfrRdData(sfrRdData), .intOscRun(intOscRun),
    .intOscFreqReady(intOscFreqReady), .sysclkTick(sysclkTick),
    .sysclkSource(sysclkSource), .usbClockSource(usbClockSource),
    .trimValue(trimValue), .trimDelta(trimDelta),
    .trimModified(trimModified), .resumeIrq(resumeIrq)
  );

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : endSim

  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // a bound that runs out ends the run at once
  task automatic tmo(input string what);
    failCount++;
    $display("Error %s expected in time seen timeout", what);
    endSim();
  endtask : tmo

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc

  // inputs change on the falling edge only
  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfrReq = '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
    @(negedge sys_clk);
    sfrReq = '0;
  endtask : sfrWrite

  // read data is registered, so it is taken one edge after the request
  task automatic sfrRead(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfrReq = '{addr: a, wrEn: 1'b0, rdEn: 1'b1, wrData: 8'h00};
    @(negedge sys_clk);
    sfrReq = '0;
    d = sfrRdData;
  endtask : sfrRead

  task automatic doReset();
    @(negedge sys_clk);
    reset_n = 1'b0;
    cyc(12);
    reset_n = 1'b1;
  endtask : doReset

  task automatic waitReady();
    for (int k = 0; k < 300; k++) begin
      @(negedge sys_clk);
      if (intOscFreqReady === 1'b1) return;
    end
    tmo("ready flag");
  endtask : waitReady

  // ticks seen over 64 cycles, phase does not matter for 8,4,2,1
  task automatic countTicks();
    n = 0;
    repeat (64) begin
      @(negedge sys_clk);
      if (sysclkTick === 1'b1) n++;
    end
  endtask : countTicks

  task automatic testReset();
    doReset();
    chk("sys source", 8'h00, {6'h00, sysclkSource});
    chk("trim value", {3'h0, factoryTrim}, {3'h0, trimValue});
    sfrRead(`IOSC_CTRL_ADDR, rd);
    chk("ctrl reset", 8'h80, rd);
    sfrRead(8'hB4, rd);
    chk("unmapped read", 8'h00, rd);
    waitReady();
    sfrRead(`IOSC_CTRL_ADDR, rd);
    chk("ctrl ready", 8'hC0, rd);
    $display("reset test done");
  endtask : testReset

  task automatic testDivide();
    for (int i = 0; i < 4; i++) begin
      sfrWrite(`IOSC_CTRL_ADDR, {6'h20, i[1:0]});
      cyc(4);
      countTicks();
      chk("tick count", 8'(8 << i), 8'(n));
    end
    // loose bits and the ready bit must not take a write
    sfrWrite(`IOSC_CTRL_ADDR, 8'h9F);
    sfrRead(`IOSC_CTRL_ADDR, rd);
    chk("ctrl loose", 8'hC3, rd);
    sfrWrite(`IOSC_CTRL_ADDR, 8'h03);
    cyc(3);
    chk("run off", 8'h00, {7'h00, intOscRun});
    countTicks();
    chk("ticks off", 8'h00, 8'(n));
    sfrRead(`IOSC_CTRL_ADDR, rd);
    chk("ctrl off", 8'h03, rd);
    sfrWrite(`IOSC_CTRL_ADDR, 8'h83);
    waitReady();
    $display("divide test done");
  endtask : testDivide

  task automatic testSuspend();
    sfrWrite(`IOSC_CTRL_ADDR, 8'hA3);
    cyc(2);
    chk("run suspended", 8'h00, {7'h00, intOscRun});
    cyc(20);
    chk("still stopped", 8'h00, {7'h00, intOscRun});
    sfrRead(`IOSC_CTRL_ADDR, rd);
    chk("ctrl suspended", 8'hA3, rd);
    usbNonIdleAsync = 1'b1;
    n = 0;
    repeat (14) begin
      @(negedge sys_clk);
      if (resumeIrq === 1'b1) n++;
    end
    chk("resume pulses", 8'h01, 8'(n));
    chk("usb wake run", 8'h01, {7'h00, intOscRun});
    usbNonIdleAsync = 1'b0;
    waitReady();
    // supply level matching the polarity wakes without an interrupt
    sfrWrite(`IOSC_CTRL_ADDR, 8'hA3);
    cyc(3);
    chk("run suspended", 8'h00, {7'h00, intOscRun});
    vbusLevelAsync = 1'b1;
    n = 0;
    repeat (14) begin
      @(negedge sys_clk);
      if (resumeIrq === 1'b1) n++;
    end
    chk("no resume", 8'h00, 8'(n));
    chk("vbus wake run", 8'h01, {7'h00, intOscRun});
    sfrRead(`IOSC_CTRL_ADDR, rd);
    chk("suspend clear", 8'h00, rd & 8'h20);
    // opposite polarity: a low supply level is now the wake condition
    vbusPolaritySelect = 1'b0;
    waitReady();
    sfrWrite(`IOSC_CTRL_ADDR, 8'hA3);
    cyc(3);
    chk("run suspended low", 8'h00, {7'h00, intOscRun});
    vbusLevelAsync = 1'b0;
    cyc(6);
    chk("low vbus wake run", 8'h01, {7'h00, intOscRun});
    vbusPolaritySelect = 1'b1;
    $display("suspend test done");
  endtask : testSuspend

  task automatic testTrim();
    sfrRead(`IOSC_TRIM_ADDR, rd);
    chk("trim read", 8'h0A, rd);
    sfrWrite(`IOSC_TRIM_ADDR, 8'hF8);
    cyc(2);
    chk("trim new", 8'h18, {3'h0, trimValue});
    chk("trim delta", 8'h0E, {2'h0, trimDelta});
    chk("trim flag", 8'h01, {7'h00, trimModified});
    clockRecoveryEn = 1'b1;
    sfrRead(`IOSC_TRIM_ADDR, rd);
    chk("trim recovery", 8'h00, rd);
    sfrWrite(`IOSC_TRIM_ADDR, 8'h05);
    clockRecoveryEn = 1'b0;
    sfrRead(`IOSC_TRIM_ADDR, rd);
    chk("trim kept", 8'h18, rd);
    doReset();
    cyc(1);
    chk("trim reload", 8'h0A, {3'h0, trimValue});
    chk("flag cleared", 8'h00, {7'h00, trimModified});
    chk("delta cleared", 8'h00, {2'h0, trimDelta});
    $display("trim test done");
  endtask : testTrim

  task automatic testSources();
    for (int i = 0; i < 4; i++) begin
      sysclkSourceReq = i[1:0];
      usbClockReq = i[1:0];
      cyc(2);
      // code 3 is not a source, so the last choice stays
      n = (i == 3) ? 2 : i;
      chk("sys source", 8'(n), {6'h00, sysclkSource});
      chk("usb source", 8'(n), {6'h00, usbClockSource});
    end
    doReset();
    chk("sys after reset", 8'h00, {6'h00, sysclkSource});
    sysclkSourceReq = 2'h0;
    usbClockReq = 2'h0;
    $display("source test done");
  endtask : testSources

  // main sequence
  initial begin
    reset_n = 1'b0;
    sfrReq = '0;
    usbNonIdleAsync = 1'b0;
    vbusLevelAsync = 1'b0;
    vbusPolaritySelect = 1'b1;
    clockRecoveryEn = 1'b0;
    factoryTrim = 5'h0A;
    sysclkSourceReq = 2'h0;
    usbClockReq = 2'h0;
    failCount = 0;
    checkCount = 0;
    testReset();
    testDivide();
    testSuspend();
    testTrim();
    testSources();
    endSim();
  end

endmodule : iosc_system_clock_control_tb_top
